// file: verilog/fbp_pkg.sv
package fbp_pkg;

  // Pointer and counter geometry
  localparam int FBP_PTR_W = 16;
  localparam int FBP_WORD_W = 6;
  localparam int FBP_PAGE_W = 8;
  localparam int FBP_ADDR_W = 14;
  localparam int FBP_PAGE_WORDS = 64;
  localparam int FBP_NARROW_COUNTER_TOP_BIT = 12;
  localparam int FBP_WIDE_COUNTER_TOP_BIT = 13;
  localparam int FBP_PAGE_WORD_TOP_BIT = 5;
  localparam int FBP_NARROW_POINTER_COUNTER_TOP_BIT = 13;
  localparam int FBP_WIDE_POINTER_COUNTER_TOP_BIT = 14;
  localparam int FBP_POINTER_PAGE_WORD_TOP_BIT = 6;

  // Boot section start per fuse pair, narrow variant
  localparam logic [13:0] FBP_BOOT13_11 = 14'h1F80;
  localparam logic [13:0] FBP_BOOT13_10 = 14'h1F00;
  localparam logic [13:0] FBP_BOOT13_01 = 14'h1E00;
  localparam logic [13:0] FBP_BOOT13_00 = 14'h1C00;
  localparam logic [13:0] FBP_END13 = 14'h1FFF;

  // Boot section start per fuse pair, wide variant
  localparam logic [13:0] FBP_BOOT14_11 = 14'h3F00;
  localparam logic [13:0] FBP_BOOT14_10 = 14'h3E00;
  localparam logic [13:0] FBP_BOOT14_01 = 14'h3C00;
  localparam logic [13:0] FBP_BOOT14_00 = 14'h3800;
  localparam logic [13:0] FBP_END14 = 14'h3FFF;

  // First word of the no-read-while-write section
  localparam logic [13:0] FBP_RWW_LIMIT13 = 14'h1C00;
  localparam logic [13:0] FBP_RWW_LIMIT14 = 14'h3800;
  localparam int FBP_RWW_PAGES13 = 112;
  localparam int FBP_RWW_PAGES14 = 224;

  // Edges after reset before the synchronised straps are trusted
  localparam logic [1:0] FBP_SETTLE_CYC = 2'h2;

  typedef enum logic [2:0] {
    FBP_OP_FILL,
    FBP_OP_ERASE,
    FBP_OP_WRITE,
    FBP_OP_READ,
    FBP_OP_RWW_EN
  } fbp_op_t;

  typedef struct packed {
    logic valid;
    fbp_op_t op;
    logic [FBP_PTR_W-1:0] pointer;
  } fbp_req_t;

  typedef struct packed {
    logic valid;
    fbp_op_t op;
    logic [FBP_PAGE_W-1:0] page_index;
    logic [FBP_WORD_W-1:0] word_in_page_index;
    logic byte_hi;
    logic in_rww;
    logic in_boot;
    logic blocked;
  } fbp_cmd_t;

  typedef struct packed {
    logic ready;
    logic wide;
    logic [FBP_ADDR_W-1:0] boot_start;
    logic [FBP_ADDR_W-1:0] rww_limit;
  } fbp_cfg_t;

  typedef struct packed {
    logic [1:0] settle;
    fbp_cfg_t cfg;
    logic section_busy_flag;
    fbp_cmd_t cmd;
  } fbp_state_t;

endpackage : fbp_pkg

// file: verilog/fbp_sync.sv
`timescale 1ns/100ps
module fbp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import fbp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } fbp_sync_state_t;

  fbp_sync_state_t st;
  fbp_sync_state_t next_st;

  always_comb begin
    next_st.meta = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule : fbp_sync

// file: verilog/fbp_addr_decode.sv
`timescale 1ns/100ps
module fbp_addr_decode (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic boot_size_fuse_hi,
  input wire logic boot_size_fuse_lo,
  input wire logic wide_variant,
  input wire fbp_pkg::fbp_req_t core_req,
  output fbp_pkg::fbp_cmd_t flash_cmd,
  output fbp_pkg::fbp_cfg_t section_cfg,
  output logic section_busy_flag
);
  import fbp_pkg::*;

  fbp_state_t st;
  fbp_state_t next_st;
  logic [2:0] straps;
  logic [FBP_PAGE_W-1:0] page_sel;
  logic [FBP_WORD_W-1:0] word_sel;
  logic [FBP_ADDR_W-1:0] word_addr;
  logic [FBP_ADDR_W-1:0] boot_pick;
  logic hit_rww;
  logic hit_boot;

  fbp_sync #(
    .WIDTH(3)
  ) u_strap_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in({wide_variant, boot_size_fuse_hi, boot_size_fuse_lo}),
    .sync_out(straps)
  );

  // Boot start from the fuse pair
  always_comb begin
    if (straps[2]) begin
      case (straps[1:0])
        2'h3: boot_pick = FBP_BOOT14_11;
        2'h2: boot_pick = FBP_BOOT14_10;
        2'h1: boot_pick = FBP_BOOT14_01;
        default: boot_pick = FBP_BOOT14_00;
      endcase
    end else begin
      case (straps[1:0])
        2'h3: boot_pick = FBP_BOOT13_11;
        2'h2: boot_pick = FBP_BOOT13_10;
        2'h1: boot_pick = FBP_BOOT13_01;
        default: boot_pick = FBP_BOOT13_00;
      endcase
    end
  end

  // Pointer to page and word; upper pointer bits dropped
  always_comb begin
    if (st.cfg.wide) begin
      page_sel = core_req.pointer[14:7];
    end else begin
      page_sel = {1'b0, core_req.pointer[13:7]};
    end
    word_sel = core_req.pointer[6:1];
    word_addr = {page_sel, word_sel};
    hit_rww = word_addr < st.cfg.rww_limit;
    hit_boot = word_addr >= st.cfg.boot_start;
  end

  always_comb begin
    next_st = st;
    next_st.cmd.valid = 1'b0;
    if (!st.cfg.ready) begin
      if (st.settle == FBP_SETTLE_CYC) begin
        next_st.cfg.ready = 1'b1;
        next_st.cfg.wide = straps[2];
        next_st.cfg.boot_start = boot_pick;
        next_st.cfg.rww_limit = straps[2] ? FBP_RWW_LIMIT14 : FBP_RWW_LIMIT13;
      end else begin
        next_st.settle = st.settle + 2'h1;
      end
    end else if (core_req.valid) begin
      next_st.cmd.valid = 1'b1;
      next_st.cmd.op = core_req.op;
      next_st.cmd.page_index = page_sel;
      next_st.cmd.word_in_page_index = word_sel;
      next_st.cmd.byte_hi = 1'b0;
      next_st.cmd.in_rww = hit_rww;
      next_st.cmd.in_boot = hit_boot;
      next_st.cmd.blocked = 1'b0;
      case (core_req.op)
        FBP_OP_ERASE, FBP_OP_WRITE: begin
          // Whole-page operations carry no word index
          next_st.cmd.word_in_page_index = '0;
          if (hit_rww) begin
            next_st.section_busy_flag = 1'b1;
          end
        end
        FBP_OP_FILL: begin
          // Starting a page load releases the section
          next_st.section_busy_flag = 1'b0;
        end
        FBP_OP_RWW_EN: begin
          next_st.section_busy_flag = 1'b0;
        end
        FBP_OP_READ: begin
          next_st.cmd.byte_hi = core_req.pointer[0];
          next_st.cmd.blocked = hit_rww && st.section_busy_flag;
        end
        default: begin
          next_st.cmd.valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flash_cmd = st.cmd;
  assign section_cfg = st.cfg;
  assign section_busy_flag = st.section_busy_flag;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_ready_req(fbp_op_t o);
    st.cfg.ready && core_req.valid && core_req.op == o;
  endsequence

  sequence s_rww_page_op;
    st.cfg.ready && core_req.valid && hit_rww && (core_req.op == FBP_OP_ERASE || core_req.op == FBP_OP_WRITE);
  endsequence

  sequence s_rww_read;
    s_ready_req(FBP_OP_READ) ##0 hit_rww;
  endsequence

  AST_BOOT13: assert property (st.cfg.ready && !st.cfg.wide |->
    st.cfg.boot_start inside {14'h1F80, 14'h1F00, 14'h1E00, 14'h1C00})
    else $error("narrow boot start not a legal boundary");

  AST_BOOT14: assert property (st.cfg.ready && st.cfg.wide |->
    st.cfg.boot_start inside {14'h3F00, 14'h3E00, 14'h3C00, 14'h3800})
    else $error("wide boot start not a legal boundary");

  AST_RWW_LIMIT: assert property (st.cfg.ready |->
    st.cfg.rww_limit == (st.cfg.wide ? 14'h3800 : 14'h1C00))
    else $error("read-while-write limit wrong for variant");

  AST_PAGE_MAP: assert property (s_ready_req(FBP_OP_ERASE) |=>
    flash_cmd.valid && flash_cmd.page_index ==
    (st.cfg.wide ? $past(core_req.pointer[14:7]) : {1'b0, $past(core_req.pointer[13:7])}))
    else $error("erase page taken from wrong pointer bits");

  AST_NARROW_TOP: assert property (flash_cmd.valid && !st.cfg.wide |->
    flash_cmd.page_index[7] == 1'b0)
    else $error("narrow variant used an ignored pointer bit");

  AST_FILL_WORD: assert property (s_ready_req(FBP_OP_FILL) |=>
    flash_cmd.word_in_page_index == $past(core_req.pointer[6:1]) && !section_busy_flag)
    else $error("fill word index wrong or busy not released");

  AST_BYTE_SEL: assert property (s_ready_req(FBP_OP_READ) |=>
    flash_cmd.byte_hi == $past(core_req.pointer[0]))
    else $error("read byte select does not follow pointer bit 0");

  AST_BLOCK_READ: assert property (s_rww_read ##0 st.section_busy_flag |=>
    flash_cmd.blocked && section_busy_flag)
    else $error("read of busy section not blocked");

  AST_BUSY_SET: assert property (s_rww_page_op |=> section_busy_flag)
    else $error("page operation on read-while-write area did not set busy");

  AST_RWW_READ_FREE: assert property (s_rww_read ##0 !st.section_busy_flag |=>
    flash_cmd.valid && !flash_cmd.blocked)
    else $error("read of idle section blocked");

  AST_OUTSIDE_FREE: assert property (s_ready_req(FBP_OP_READ) ##0 !hit_rww |=>
    flash_cmd.valid && !flash_cmd.blocked)
    else $error("read outside read-while-write area blocked");

  AST_RWW_EN_CLR: assert property (s_ready_req(FBP_OP_RWW_EN) |=> !section_busy_flag)
    else $error("section re-enable did not clear busy");

  AST_CFG_HOLD: assert property (st.cfg.ready ##1 1'b1 |->
    $stable(st.cfg.boot_start) && $stable(st.cfg.wide) && st.cfg.ready)
    else $error("section boundaries changed after capture");

  AST_READY_TIME: assert property ($fell(sys_rst) |-> !st.cfg.ready ##3 st.cfg.ready)
    else $error("boundaries not captured three edges after reset");

  AST_NO_EARLY: assert property (!st.cfg.ready |=> !flash_cmd.valid)
    else $error("request answered before boundaries were captured");

  AST_RWW_PAGES: assert property (flash_cmd.valid |->
    flash_cmd.in_rww == (flash_cmd.page_index < (st.cfg.wide ? FBP_RWW_PAGES14 : FBP_RWW_PAGES13)))
    else $error("read-while-write flag disagrees with page count");

  AST_WRITE_PAGE: assert property (s_ready_req(FBP_OP_WRITE) |=>
    flash_cmd.valid && flash_cmd.word_in_page_index == 6'h00 && flash_cmd.page_index ==
    (st.cfg.wide ? $past(core_req.pointer[14:7]) : {1'b0, $past(core_req.pointer[13:7])}))
    else $error("write page or word index wrong");

endmodule : fbp_addr_decode

// file: test/fbp_core_model.sv
`timescale 1ns/100ps
module fbp_core_model (
  input wire logic clk_sys,
  output fbp_pkg::fbp_req_t core_req
);
  import fbp_pkg::*;

  initial core_req = '0;

  // One request per call; released pointer lines are scrambled
  task automatic send(input fbp_op_t op, input logic [15:0] ptr);
    logic [15:0] p;
    p = ptr;
    if (op != FBP_OP_READ) p[0] = 1'b0;
    if (op == FBP_OP_WRITE) p[6:1] = 6'h00;
    @(posedge clk_sys);
    #1 core_req = '{valid: 1'b1, op: op, pointer: p};
    @(posedge clk_sys);
    #1 core_req = '{valid: 1'b0, op: op, pointer: ~p};
  endtask : send
endmodule : fbp_core_model

// file: test/fbp_addr_decode_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module fbp_addr_decode_tb_top;
  import fbp_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic boot_size_fuse_hi = 1'b1;
  logic boot_size_fuse_lo = 1'b1;
  logic wide_variant = 1'b0;
  fbp_req_t core_req;
  fbp_cmd_t flash_cmd;
  fbp_cfg_t section_cfg;
  logic section_busy_flag;
  int n_errors = 0;
  int check_count = 0;

  always #12.5 clk_sys = ~clk_sys;

  fbp_core_model u_core (.clk_sys(clk_sys), .core_req(core_req));

  fbp_addr_decode u_dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .boot_size_fuse_hi(boot_size_fuse_hi),
    .boot_size_fuse_lo(boot_size_fuse_lo),
    .wide_variant(wide_variant),
    .core_req(core_req),
    .flash_cmd(flash_cmd),
    .section_cfg(section_cfg),
    .section_busy_flag(section_busy_flag)
  );

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic restart(input logic w, input logic [1:0] fz);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1 sys_rst = 1'b1;
    {boot_size_fuse_hi, boot_size_fuse_lo, wide_variant} = {fz, w};
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    while (section_cfg.ready !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK("settle", 3, n)
  endtask : restart

  task automatic xfer(input fbp_op_t op, input logic [15:0] p, input logic [13:0] bs, input logic b0, b1);
    logic [7:0] pg;
    logic [5:0] wd;
    logic [13:0] a;
    logic r;
    logic [3:0] ef;
    pg = wide_variant ? p[14:7] : {1'b0, p[13:7]};
    wd = (op == FBP_OP_ERASE || op == FBP_OP_WRITE) ? 6'h00 : p[6:1];
    a = {pg, wd};
    r = a < (wide_variant ? 14'h3800 : 14'h1C00);
    ef = {p[0] & (op == FBP_OP_READ), r, a >= bs, r & b0 & (op == FBP_OP_READ)};
    u_core.send(op, p);
    `CHK("valid", 1'b1, flash_cmd.valid)
    `CHK("op", op, flash_cmd.op)
    `CHK("addr", a, {flash_cmd.page_index, flash_cmd.word_in_page_index})
    `CHK("flags", ef, {flash_cmd.byte_hi, flash_cmd.in_rww, flash_cmd.in_boot, flash_cmd.blocked})
    `CHK("busy", b1, section_busy_flag)
  endtask : xfer

  task automatic t_cfg;
    logic [13:0] b13 [4] = '{14'h1C00, 14'h1E00, 14'h1F00, 14'h1F80};
    logic [13:0] b14 [4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
    for (int f = 0; f < 4; f++) begin
      restart(1'b0, f[1:0]);
      `CHK("boot13", b13[f], section_cfg.boot_start)
      `CHK("rww13", 14'h1C00, section_cfg.rww_limit)
      restart(1'b1, f[1:0]);
      `CHK("boot14", b14[f], section_cfg.boot_start)
      `CHK("rww14", 14'h3800, section_cfg.rww_limit)
    end
    @(posedge clk_sys);
    #1 {boot_size_fuse_hi, boot_size_fuse_lo, wide_variant} = 3'h0;
    repeat (5) @(posedge clk_sys);
    `CHK("hold", 15'h7F00, {section_cfg.wide, section_cfg.boot_start})
    $display("t_cfg done");
  endtask : t_cfg

  task automatic t_map;
    restart(1'b0, 2'h3);
    xfer(FBP_OP_FILL, 16'hFFFE, 14'h1F80, 1'b0, 1'b0);
    xfer(FBP_OP_READ, 16'h37FF, 14'h1F80, 1'b0, 1'b0);
    xfer(FBP_OP_READ, 16'h3800, 14'h1F80, 1'b0, 1'b0);
    xfer(FBP_OP_ERASE, 16'h3F00, 14'h1F80, 1'b0, 1'b0);
    restart(1'b1, 2'h0);
    xfer(FBP_OP_FILL, 16'hFFFE, 14'h3800, 1'b0, 1'b0);
    xfer(FBP_OP_READ, 16'h6FFF, 14'h3800, 1'b0, 1'b0);
    xfer(FBP_OP_READ, 16'h7000, 14'h3800, 1'b0, 1'b0);
    $display("t_map done");
  endtask : t_map

  task automatic t_busy;
    xfer(FBP_OP_ERASE, 16'h0080, 14'h3800, 1'b0, 1'b1);
    xfer(FBP_OP_READ, 16'h0081, 14'h3800, 1'b1, 1'b1);
    xfer(FBP_OP_READ, 16'h7001, 14'h3800, 1'b1, 1'b1);
    xfer(FBP_OP_FILL, 16'h0002, 14'h3800, 1'b1, 1'b0);
    xfer(FBP_OP_WRITE, 16'h0100, 14'h3800, 1'b0, 1'b1);
    xfer(FBP_OP_RWW_EN, 16'h0000, 14'h3800, 1'b1, 1'b0);
    xfer(FBP_OP_READ, 16'h0081, 14'h3800, 1'b0, 1'b0);
    $display("t_busy done");
  endtask : t_busy

  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    t_cfg();
    t_map();
    t_busy();
    end_of_test();
  end
endmodule : fbp_addr_decode_tb_top
